// ---- inc/bf_pkg.sv ----
// Constants shared by the breaker failure scheme
package bf_pkg;
    // Data widths and counts
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 32;
    localparam int CUR_W   = 16;
    localparam int DELAY_W = 16;
    localparam int NUM_CFG = 12;
    localparam int SYNC_N  = 11;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL      = 8'h00;
    localparam logic [7:0] OFF_PH_SUPV   = 8'h04;
    localparam logic [7:0] OFF_N_SUPV    = 8'h08;
    localparam logic [7:0] OFF_PH_HI     = 8'h0c;
    localparam logic [7:0] OFF_N_HI      = 8'h10;
    localparam logic [7:0] OFF_PH_LO     = 8'h14;
    localparam logic [7:0] OFF_N_LO      = 8'h18;
    localparam logic [7:0] OFF_EARLY_DLY = 8'h1c;
    localparam logic [7:0] OFF_MAIN_DLY  = 8'h20;
    localparam logic [7:0] OFF_SLOW_DLY  = 8'h24;
    localparam logic [7:0] OFF_LO_DLY    = 8'h28;
    localparam logic [7:0] OFF_HOLD      = 8'h2c;
    localparam logic [7:0] OFF_STATUS    = 8'h30;

    // Control register fields
    localparam int CTRL_MODE_BIT  = 0;
    localparam int CTRL_GI_BIT    = 1;
    localparam int CTRL_LATCH_BIT = 2;
    localparam int CTRL_EARLY_BIT = 3;
    localparam int CTRL_MAIN_BIT  = 4;
    localparam int CTRL_SLOW_BIT  = 5;
    localparam logic [15:0] CTRL_MASK = 16'h003f;

    // Status register fields
    localparam int ST_DECL_BIT   = 0;
    localparam int ST_TRIP_BIT   = 1;
    localparam int ST_RETRIP_LSB = 2;
    localparam int ST_FAIL_LSB   = 5;

    // Reset values
    localparam logic [15:0] RST_CTRL   = 16'h0000;
    localparam logic [15:0] RST_THRESH = 16'h041a;
    localparam logic [15:0] RST_DELAY  = 16'h0000;
    localparam logic [15:0] CFG_RST [NUM_CFG] = '{
        RST_CTRL, RST_THRESH, RST_THRESH, RST_THRESH, RST_THRESH,
        RST_THRESH, RST_THRESH, RST_DELAY, RST_DELAY, RST_DELAY,
        RST_DELAY, RST_DELAY};

    // Timing: delays count in 1 ms steps of the system clock
    localparam int CLK_MHZ     = 100;
    localparam int TICK_US     = 1000;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
endpackage

// ---- src/bf_delay_timer.sv ----
// Millisecond pickup delay timer that restarts when its run condition drops
`timescale 1ns/1ps
`default_nettype none
module bf_delay_timer #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         arst_n,
    // Timing control
    input  wire logic         tick,
    input  wire logic         run,
    input  wire logic [W-1:0] delay,
    // Expiry level
    output var  logic         done
);
    logic [W-1:0] count;
    logic [W-1:0] next_count;
    logic         next_done;

    if (W < 1 || W > 31)
    begin : g_chk
        $error("bf_delay_timer: width out of range");
    end

    always_comb
    begin
        next_count = count;
        if (!run)
        begin
            next_count = '0;
        end
        else if (tick && (count < delay))
        begin
            next_count = count + 1'b1;
        end
        next_done = run && (count >= delay);
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            count <= '0;
            done  <= 1'b0;
        end
        else
        begin
            count <= next_count;
            done  <= next_done;
        end
    end
endmodule
`default_nettype wire

// ---- src/bf_scheme.sv ----
// Breaker failure scheme with APB settings and status registers
// Summary of operation
// - Pole mode selects single-pole or three-pole inputs.
// - Gated initiate accepts initiate only above supervision current.
// - Gated latch holds seal-in only while current exceeds supervision.
// - In three-pole mode, three-pole initiate re-trips and starts three-pole failure logic.
// - Phase supervision threshold gates both initiate and seal-in.
// - Neutral thresholds act only in three-pole mode.
// - Early path declares failure only when enabled.
// - Main path declares failure only when enabled.
// - Slow path declares failure only when enabled.
// - Magnitudes lag interruption by one power cycle.
// - An input flags the breaker out of service.
// - High thresholds supervise output before resistor insertion.
// - Low thresholds supervise output after resistor insertion.
// - A programmable delay activates low-threshold detection.
// - Failure trip seals in for hold time and drives cancel-reclose.
// - Single-pole: each pole initiate re-trips and starts its own pole.
// - Single-pole mode uses per-pole early and normal auxiliary contacts.
// - Per-pole logic shares one set of thresholds.
// - Single-pole failure gives a three-pole failure trip.
// - Accepted initiate immediately re-trips the signalled breaker.
// - Early or main expiry enables high detector and low timer.
// - Delays span 0 to 65.535 s in 1 ms steps.
// - Slow path needs closed contact and in-service breaker.
`timescale 1ns/1ps
`default_nettype none
module bf_scheme #(
    parameter int TICK_CYCLES = bf_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      arst_n,
    // APB slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [bf_pkg::ADDR_W-1:0] paddr,
    input  wire logic [bf_pkg::DATA_W-1:0] pwdata,
    output var  logic [bf_pkg::DATA_W-1:0] prdata,
    output var  logic                      pready,
    output var  logic                      pslverr,
    // Filtered current magnitudes, 0.001 pu units
    input  wire logic [bf_pkg::CUR_W-1:0]  phase_current_a,
    input  wire logic [bf_pkg::CUR_W-1:0]  phase_current_b,
    input  wire logic [bf_pkg::CUR_W-1:0]  phase_current_c,
    input  wire logic [bf_pkg::CUR_W-1:0]  neutral_current,
    // Initiate inputs
    input  wire logic                      three_pole_initiate_in,
    input  wire logic                      pole_a_initiate_in,
    input  wire logic                      pole_b_initiate_in,
    input  wire logic                      pole_c_initiate_in,
    // Breaker auxiliary contacts, high while breaker closed, and out-of-service flag
    input  wire logic                      pole_a_early_contact_in,
    input  wire logic                      pole_b_early_contact_in,
    input  wire logic                      pole_c_early_contact_in,
    input  wire logic                      pole_a_normal_contact_in,
    input  wire logic                      pole_b_normal_contact_in,
    input  wire logic                      pole_c_normal_contact_in,
    input  wire logic                      out_of_service_in,
    // Trip outputs
    output var  logic [2:0]                retrip_out,
    output var  logic                      failure_trip_out,
    output var  logic                      cancel_reclose_out,
    output var  logic                      failure_declared_out
);
    localparam int DW = bf_pkg::DELAY_W;
    localparam int CW = bf_pkg::CUR_W;
    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
    localparam logic [3:0] IDX_STATUS = bf_pkg::OFF_STATUS[5:2];

    if (TICK_CYCLES < 1)
    begin : g_chk
        $error("bf_scheme: TICK_CYCLES must be at least 1");
    end

    // Pin synchroniser, three stages with agreement filter
    logic [bf_pkg::SYNC_N-1:0] pin_raw;
    logic [bf_pkg::SYNC_N-1:0] sync1;
    logic [bf_pkg::SYNC_N-1:0] sync2;
    logic [bf_pkg::SYNC_N-1:0] sync3;
    logic [bf_pkg::SYNC_N-1:0] pin_flt;
    logic [bf_pkg::SYNC_N-1:0] next_pin_flt;

    assign pin_raw = {out_of_service_in,
                      pole_c_normal_contact_in, pole_b_normal_contact_in,
                      pole_a_normal_contact_in,
                      pole_c_early_contact_in, pole_b_early_contact_in,
                      pole_a_early_contact_in,
                      pole_c_initiate_in, pole_b_initiate_in,
                      pole_a_initiate_in, three_pole_initiate_in};

    always_comb
    begin
        next_pin_flt = (sync2 & sync3) | (pin_flt & (sync2 | sync3));
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync1   <= '0;
            sync2   <= '0;
            sync3   <= '0;
            pin_flt <= '0;
        end
        else
        begin
            sync1   <= pin_raw;
            sync2   <= sync1;
            sync3   <= sync2;
            pin_flt <= next_pin_flt;
        end
    end

    logic       tp_init;
    logic [2:0] pole_init_pin;
    logic [2:0] early_pin;
    logic [2:0] normal_pin;
    logic       oos;

    assign tp_init       = pin_flt[0];
    assign pole_init_pin = pin_flt[3:1];
    assign early_pin     = pin_flt[6:4];
    assign normal_pin    = pin_flt[9:7];
    assign oos           = pin_flt[10];

    // Millisecond tick
    logic [TW-1:0] tick_cnt;
    logic [TW-1:0] next_tick_cnt;
    logic          tick;
    logic          next_tick;

    always_comb
    begin
        next_tick     = (tick_cnt == TICK_LAST);
        next_tick_cnt = next_tick ? '0 : tick_cnt + 1'b1;
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end
        else
        begin
            tick_cnt <= next_tick_cnt;
            tick     <= next_tick;
        end
    end

    // Settings registers
    logic [15:0] cfg [bf_pkg::NUM_CFG];
    logic [15:0] next_cfg [bf_pkg::NUM_CFG];

    logic          single;
    logic          three;
    logic          use_gi;
    logic          use_latch;
    logic          early_en;
    logic          main_en;
    logic          slow_en;
    logic [CW-1:0] ph_supv;
    logic [CW-1:0] n_supv;
    logic [CW-1:0] ph_hi;
    logic [CW-1:0] n_hi;
    logic [CW-1:0] ph_lo;
    logic [CW-1:0] n_lo;
    logic [DW-1:0] early_dly;
    logic [DW-1:0] main_dly;
    logic [DW-1:0] slow_dly;
    logic [DW-1:0] lo_dly;
    logic [DW-1:0] hold_dly;

    assign single    = cfg[bf_pkg::OFF_CTRL[5:2]][bf_pkg::CTRL_MODE_BIT];
    assign three     = !single;
    assign use_gi    = cfg[bf_pkg::OFF_CTRL[5:2]][bf_pkg::CTRL_GI_BIT];
    assign use_latch = cfg[bf_pkg::OFF_CTRL[5:2]][bf_pkg::CTRL_LATCH_BIT];
    assign early_en  = cfg[bf_pkg::OFF_CTRL[5:2]][bf_pkg::CTRL_EARLY_BIT];
    assign main_en   = cfg[bf_pkg::OFF_CTRL[5:2]][bf_pkg::CTRL_MAIN_BIT];
    assign slow_en   = cfg[bf_pkg::OFF_CTRL[5:2]][bf_pkg::CTRL_SLOW_BIT];
    assign ph_supv   = cfg[bf_pkg::OFF_PH_SUPV[5:2]];
    assign n_supv    = cfg[bf_pkg::OFF_N_SUPV[5:2]];
    assign ph_hi     = cfg[bf_pkg::OFF_PH_HI[5:2]];
    assign n_hi      = cfg[bf_pkg::OFF_N_HI[5:2]];
    assign ph_lo     = cfg[bf_pkg::OFF_PH_LO[5:2]];
    assign n_lo      = cfg[bf_pkg::OFF_N_LO[5:2]];
    assign early_dly = cfg[bf_pkg::OFF_EARLY_DLY[5:2]];
    assign main_dly  = cfg[bf_pkg::OFF_MAIN_DLY[5:2]];
    assign slow_dly  = cfg[bf_pkg::OFF_SLOW_DLY[5:2]];
    assign lo_dly    = cfg[bf_pkg::OFF_LO_DLY[5:2]];
    assign hold_dly  = cfg[bf_pkg::OFF_HOLD[5:2]];

    // Per-pole scheme
    logic [CW-1:0] ph_cur [3];
    logic [2:0]    init;
    logic [2:0]    sup;
    logic [2:0]    acc;
    logic [2:0]    seal;
    logic [2:0]    next_seal;
    logic [2:0]    active;
    logic [2:0]    t1_run;
    logic [2:0]    t2_run;
    logic [2:0]    t3_run;
    logic [2:0]    lo_run;
    logic [2:0]    t1_done;
    logic [2:0]    t2_done;
    logic [2:0]    t3_done;
    logic [2:0]    lo_done;
    logic [2:0]    hi_det;
    logic [2:0]    lo_det;
    logic [2:0]    cur_ok;
    logic [2:0]    fail;
    logic          n_supv_det;
    logic          n_hi_det;
    logic          n_lo_det;

    assign ph_cur[0] = phase_current_a;
    assign ph_cur[1] = phase_current_b;
    assign ph_cur[2] = phase_current_c;

    // Magnitudes are post-filter and lag interruption by a cycle
    assign n_supv_det = three && (neutral_current > n_supv);
    assign n_hi_det   = three && (neutral_current > n_hi);
    assign n_lo_det   = three && (neutral_current > n_lo);

    for (genvar p = 0; p < 3; p++)
    begin : g_pole
        logic early_c;
        logic normal_c;

        assign init[p]   = single ? pole_init_pin[p] : tp_init;
        assign early_c   = single ? early_pin[p] : early_pin[0];
        assign normal_c  = single ? normal_pin[p] : normal_pin[0];
        assign sup[p]    = (ph_cur[p] > ph_supv) || n_supv_det;
        assign acc[p]    = init[p] && (!use_gi || sup[p]);
        assign active[p] = acc[p] || seal[p];
        assign t1_run[p] = active[p] && early_en && early_c;
        assign t2_run[p] = active[p] && main_en;
        assign t3_run[p] = active[p] && slow_en && normal_c && !oos;
        assign lo_run[p] = t1_done[p] || t2_done[p];
        assign hi_det[p] = (ph_cur[p] > ph_hi) || n_hi_det;
        assign lo_det[p] = (ph_cur[p] > ph_lo) || n_lo_det;
        assign cur_ok[p] = hi_det[p] || (lo_done[p] && lo_det[p]);
        assign fail[p]   = (((early_en && t1_done[p]) || (main_en && t2_done[p]))
                            && cur_ok[p]) || (slow_en && t3_done[p]);

        bf_delay_timer #(.W(DW)) u_early (
            .clk_sys (clk_sys),
            .arst_n  (arst_n),
            .tick    (tick),
            .run     (t1_run[p]),
            .delay   (early_dly),
            .done    (t1_done[p])
        );

        bf_delay_timer #(.W(DW)) u_main (
            .clk_sys (clk_sys),
            .arst_n  (arst_n),
            .tick    (tick),
            .run     (t2_run[p]),
            .delay   (main_dly),
            .done    (t2_done[p])
        );

        bf_delay_timer #(.W(DW)) u_slow (
            .clk_sys (clk_sys),
            .arst_n  (arst_n),
            .tick    (tick),
            .run     (t3_run[p]),
            .delay   (slow_dly),
            .done    (t3_done[p])
        );

        bf_delay_timer #(.W(DW)) u_low (
            .clk_sys (clk_sys),
            .arst_n  (arst_n),
            .tick    (tick),
            .run     (lo_run[p]),
            .delay   (lo_dly),
            .done    (lo_done[p])
        );
    end

    // Seal-in and trip output
    logic fail_any;
    logic hold_run;
    logic hold_done;
    logic next_trip;
    logic decl_sticky;
    logic next_decl_sticky;

    assign fail_any = |fail;
    assign hold_run = failure_trip_out && !fail_any;

    bf_delay_timer #(.W(DW)) u_hold (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .tick    (tick),
        .run     (hold_run),
        .delay   (hold_dly),
        .done    (hold_done)
    );

    // APB decode
    logic        apb_done;
    logic        addr_ok;
    logic [3:0]  idx;
    logic        wr_status;
    logic        next_pready;
    logic        next_pslverr;
    logic [31:0] next_prdata;
    logic [31:0] rd_val;
    logic [31:0] status_val;

    assign idx       = paddr[5:2];
    assign addr_ok   = (paddr[7:6] == 2'h0) && (paddr[1:0] == 2'h0) && (idx <= IDX_STATUS);
    assign apb_done  = psel && penable && pready;
    assign wr_status = apb_done && pwrite && addr_ok && (idx == IDX_STATUS);

    assign status_val = {24'h000000, fail, active, failure_trip_out, decl_sticky};

    always_comb
    begin
        next_seal = acc | (seal & active & {3{use_latch}} & sup);
        next_trip = fail_any || (failure_trip_out && !hold_done);
        next_decl_sticky = fail_any
            || (decl_sticky && !(wr_status && pwdata[bf_pkg::ST_DECL_BIT]));
        if (idx == IDX_STATUS)
        begin
            rd_val = status_val;
        end
        else if (idx < 4'(bf_pkg::NUM_CFG))
        begin
            rd_val = {16'h0000, cfg[idx]};
        end
        else
        begin
            rd_val = 32'h00000000;
        end
        next_pready  = psel && penable && !pready;
        next_pslverr = next_pready && !addr_ok;
        next_prdata  = (next_pready && !pwrite && addr_ok) ? rd_val : 32'h00000000;
        for (int i = 0; i < bf_pkg::NUM_CFG; i++)
        begin
            next_cfg[i] = cfg[i];
        end
        if (apb_done && pwrite && addr_ok && (idx < 4'(bf_pkg::NUM_CFG)))
        begin
            if (idx == bf_pkg::OFF_CTRL[5:2])
            begin
                next_cfg[idx] = pwdata[15:0] & bf_pkg::CTRL_MASK;
            end
            else
            begin
                next_cfg[idx] = pwdata[15:0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            seal                 <= 3'h0;
            retrip_out           <= 3'h0;
            failure_trip_out     <= 1'b0;
            cancel_reclose_out   <= 1'b0;
            failure_declared_out <= 1'b0;
            decl_sticky          <= 1'b0;
            pready               <= 1'b0;
            pslverr              <= 1'b0;
            prdata               <= 32'h00000000;
            for (int i = 0; i < bf_pkg::NUM_CFG; i++)
            begin
                cfg[i] <= bf_pkg::CFG_RST[i];
            end
        end
        else
        begin
            seal                 <= next_seal;
            retrip_out           <= acc | seal;
            failure_trip_out     <= next_trip;
            cancel_reclose_out   <= next_trip;
            failure_declared_out <= fail_any;
            decl_sticky          <= next_decl_sticky;
            pready               <= next_pready;
            pslverr              <= next_pslverr;
            prdata               <= next_prdata;
            for (int i = 0; i < bf_pkg::NUM_CFG; i++)
            begin
                cfg[i] <= next_cfg[i];
            end
        end
    end
endmodule
`default_nettype wire

// ---- verif/bf_scheme_checker.sv ----
// Port-level assertions for the breaker failure scheme
`timescale 1ns/1ps
`default_nettype none
module bf_scheme_checker #(
    parameter int TICK_CYCLES = 4
) (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        arst_n,
    // Register bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Trip outputs
    input wire logic [2:0]  retrip_out,
    input wire logic        failure_trip_out,
    input wire logic        cancel_reclose_out,
    input wire logic        failure_declared_out
);
    logic any_retrip;
    assign any_retrip = |retrip_out;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    property p_cancel; cancel_reclose_out == failure_trip_out; endproperty
    a_cancel: assert property (p_cancel)
        else $error("cancel differs from trip");
    property p_decl_trip; failure_declared_out |-> failure_trip_out; endproperty
    a_decl_trip: assert property (p_decl_trip)
        else $error("declared without trip");
    property p_trip_rise; $rose(failure_trip_out) |-> $past(any_retrip); endproperty
    a_trip_rise: assert property (p_trip_rise)
        else $error("trip without prior retrip");
    property p_trip_fall; $fell(failure_trip_out) |-> !$past(failure_declared_out); endproperty
    a_trip_fall: assert property (p_trip_fall)
        else $error("trip fell while declared");
    property p_wait; psel && $rose(penable) |-> !pready ##1 pready; endproperty
    a_wait: assert property (p_wait)
        else $error("ready not in second access cycle");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse)
        else $error("ready longer than one cycle");
    property p_idle; !pready |-> prdata == '0; endproperty
    a_idle: assert property (p_idle)
        else $error("read data not zero idle");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err)
        else $error("error flag without ready");
endmodule

bind bf_scheme bf_scheme_checker #(.TICK_CYCLES(TICK_CYCLES)) bf_scheme_checker_i (
    .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .retrip_out(retrip_out),
    .failure_trip_out(failure_trip_out), .cancel_reclose_out(cancel_reclose_out),
    .failure_declared_out(failure_declared_out));
`default_nettype wire

// ---- verif/bf_breaker_model.sv ----
// Behavioural breaker with auxiliary contacts and current magnitudes
`timescale 1ns/1ps
`default_nettype none
module bf_breaker_model #(
    parameter int OPEN_CYC = 6,
    parameter int LAG_CYC  = 4
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    // Trip coils and test controls
    input  wire logic [2:0]  trip,
    input  wire logic        reclose,
    input  wire logic        fault,
    input  wire logic        stuck_mech,
    input  wire logic        stuck_arc,
    input  wire logic [15:0] level,
    // Auxiliary contacts, high while closed
    output var  logic [2:0]  early_closed,
    output var  logic [2:0]  normal_closed,
    // Magnitudes seen by the relay
    output var  logic [15:0] cur_a,
    output var  logic [15:0] cur_b,
    output var  logic [15:0] cur_c,
    output var  logic [15:0] cur_n
);
    int         cnt [3];
    logic [2:0] flow;
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        for (int p = 0; p < 3; p++)
        begin
            if (!arst_n || reclose)
                cnt[p] <= 0;
            else if ((trip[p] || cnt[p] > 0) && cnt[p] < 255)
                cnt[p] <= cnt[p] + 1;
        end
    end
    always_comb
    begin
        for (int p = 0; p < 3; p++)
        begin
            early_closed[p]  = stuck_mech || cnt[p] < OPEN_CYC / 2;
            normal_closed[p] = stuck_mech || cnt[p] < OPEN_CYC;
            // Magnitude lingers for a lag after the arc clears
            flow[p] = fault && (stuck_mech || stuck_arc || cnt[p] < OPEN_CYC + LAG_CYC);
        end
        cur_a = flow[0] ? level : 16'h0000;
        cur_b = flow[1] ? level : 16'h0000;
        cur_c = flow[2] ? level : 16'h0000;
        cur_n = flow[0] ? level : 16'h0000;
    end
endmodule
`default_nettype wire

// ---- verif/bf_scheme_tb_top.sv ----
// Self-checking testbench for the breaker failure scheme
`timescale 1ns/1ps
`default_nettype none
module bf_scheme_tb_top;
    localparam int TICK = 4;
    logic             clk_sys = 1'b0;
    logic             arst_n = 1'b0;
    logic             psel = 1'b0;
    logic             penable = 1'b0;
    logic             pwrite = 1'b0;
    logic [7:0]       paddr = 8'h00;
    logic [31:0]      pwdata = 32'h0;
    logic [3:0]       ini = 4'h0;
    logic             fault = 1'b0;
    logic             smech = 1'b0;
    logic             sarc = 1'b0;
    logic             reclose = 1'b0;
    logic             oos = 1'b0;
    logic [15:0]      level = 16'h2000;
    wire logic [31:0] prdata;
    wire logic        pready, pslverr, ftrip, cancel, decl;
    wire logic [2:0]  ec, nc, retrip_out;
    wire logic [15:0] ca, cb, cc, cn;
    int               error_cnt = 0;
    int               compares = 0;
    logic             tr;
    logic [2:0]       rt;
    int               hc;
    logic [31:0]      r;
    logic             e;

    always #5 clk_sys = ~clk_sys;

    bf_scheme #(.TICK_CYCLES(TICK)) bf_scheme_i (
        .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .phase_current_a(ca),
        .phase_current_b(cb), .phase_current_c(cc), .neutral_current(cn),
        .three_pole_initiate_in(ini[0]), .pole_a_initiate_in(ini[1]),
        .pole_b_initiate_in(ini[2]), .pole_c_initiate_in(ini[3]),
        .pole_a_early_contact_in(ec[0]), .pole_b_early_contact_in(ec[1]),
        .pole_c_early_contact_in(ec[2]), .pole_a_normal_contact_in(nc[0]),
        .pole_b_normal_contact_in(nc[1]), .pole_c_normal_contact_in(nc[2]),
        .out_of_service_in(oos), .retrip_out(retrip_out), .failure_trip_out(ftrip),
        .cancel_reclose_out(cancel), .failure_declared_out(decl));

    bf_breaker_model bf_breaker_model_i (
        .clk_sys(clk_sys), .arst_n(arst_n), .trip(retrip_out | {3{ftrip}}),
        .reclose(reclose), .fault(fault), .stuck_mech(smech), .stuck_arc(sarc),
        .level(level), .early_closed(ec), .normal_closed(nc), .cur_a(ca),
        .cur_b(cb), .cur_c(cc), .cur_n(cn));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
            @(posedge clk_sys);
        while (pready !== 1'b1 && ++n < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
            error_cnt++;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic xe);
        apb(1'b0, a, 32'h0);
        chk(r, x);
        chk(e, xe);
    endtask

    // One initiate episode
    task automatic shot(input logic [3:0] i);
        tr = 1'b0;
        rt = 3'b000;
        hc = 0;
        @(posedge clk_sys);
        ini <= i;
        fault <= 1'b1;
        repeat (80)
        begin
            @(posedge clk_sys);
            tr |= ftrip;
            rt |= retrip_out;
        end
        ini <= 4'h0;
        fault <= 1'b0;
        repeat (60)
        begin
            @(posedge clk_sys);
            if (ftrip && !decl)
                hc++;
        end
        reclose <= 1'b1;
        @(posedge clk_sys);
        reclose <= 1'b0;
        repeat (8) @(posedge clk_sys);
    endtask

    task automatic t_regs;
        rdc(bf_pkg::OFF_CTRL, 32'h0, 1'b0);
        rdc(bf_pkg::OFF_PH_SUPV, 32'h041a, 1'b0);
        rdc(8'h34, 32'h0, 1'b1);
        wr(bf_pkg::OFF_CTRL, 32'hffffffff);
        rdc(bf_pkg::OFF_CTRL, 32'h3f, 1'b0);
        wr(bf_pkg::OFF_SLOW_DLY, 32'h0001ffff);
        rdc(bf_pkg::OFF_SLOW_DLY, 32'hffff, 1'b0);
        wr(bf_pkg::OFF_SLOW_DLY, 32'h6);
        wr(bf_pkg::OFF_MAIN_DLY, 32'h5);
        wr(bf_pkg::OFF_EARLY_DLY, 32'h4);
        wr(bf_pkg::OFF_HOLD, 32'h2);
    endtask

    task automatic t_main;
        wr(bf_pkg::OFF_CTRL, 32'h10);
        shot(4'h1);
        chk(rt, 3'b111);
        chk(tr, 1'b0);
        sarc <= 1'b1;
        shot(4'h1);
        chk(tr, 1'b1);
        chk(hc >= 1 + TICK && hc <= 2 * TICK + 3, 1'b1);
        rdc(bf_pkg::OFF_STATUS, 32'h1, 1'b0);
        wr(bf_pkg::OFF_STATUS, 32'h1);
        rdc(bf_pkg::OFF_STATUS, 32'h0, 1'b0);
        sarc <= 1'b0;
    endtask

    task automatic t_early;
        wr(bf_pkg::OFF_CTRL, 32'h0);
        smech <= 1'b1;
        shot(4'h1);
        chk(tr, 1'b0);
        chk(rt, 3'b111);
        wr(bf_pkg::OFF_CTRL, 32'h08);
        shot(4'h1);
        chk(tr, 1'b1);
        smech <= 1'b0;
        sarc <= 1'b1;
        shot(4'h1);
        chk(tr, 1'b0);
        sarc <= 1'b0;
    endtask

    task automatic t_slow;
        smech <= 1'b1;
        oos <= 1'b1;
        level <= 16'h0000;
        wr(bf_pkg::OFF_CTRL, 32'h20);
        shot(4'h1);
        chk(tr, 1'b0);
        oos <= 1'b0;
        shot(4'h1);
        chk(tr, 1'b1);
        smech <= 1'b0;
        level <= 16'h2000;
    endtask

    task automatic t_gated;
        level <= 16'h0100;
        wr(bf_pkg::OFF_CTRL, 32'h12);
        shot(4'h1);
        chk(rt, 3'b000);
        level <= 16'h2000;
        shot(4'h1);
        chk(rt, 3'b111);
    endtask

    task automatic t_single;
        sarc <= 1'b1;
        wr(bf_pkg::OFF_CTRL, 32'h11);
        shot(4'h4);
        chk(rt, 3'b010);
        chk(tr, 1'b1);
        sarc <= 1'b0;
    endtask

    task automatic wrap_up;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        #200000;
        error_cnt++;
        wrap_up();
    end

    initial
    begin
        repeat (6) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_regs();
        t_main();
        t_early();
        t_slow();
        t_gated();
        t_single();
        wrap_up();
    end
endmodule
`default_nettype wire
